// [srn_pkg.sv]
// constants and carrier types of the service request node block
`default_nettype none

package srn_pkg;

  // ---------------------------------------------------------------
  // node control word layout
  // ---------------------------------------------------------------
  localparam int PRIO_LSB = 0;
  localparam int PRIO_W = 8;
  localparam int SEL_LO_BIT = 10;
  localparam int SEL_HI_BIT = 11;
  localparam int EN_BIT = 12;
  localparam int PEND_BIT = 13;
  localparam int CLR_BIT = 14;
  localparam int SET_BIT = 15;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam logic [ADDR_W-1:0] NODE_BASE = 9'h000;
  localparam logic [ADDR_W-1:0] PEND_STATUS_OFS = 9'h100;
  localparam logic [ADDR_W-1:0] CPU_WIN_OFS = 9'h104;
  localparam logic [ADDR_W-1:0] COP_WIN_OFS = 9'h108;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_RST = 8'h00;
  localparam logic SEL_RST = 1'b0;
  localparam logic EN_RST = 1'b0;
  localparam logic PEND_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // provider select encoding of the low select bit
  localparam logic SEL_CPU = 1'b0;
  localparam logic SEL_COP = 1'b1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PRIO_W-1:0] prio;
    logic sel;
    logic en;
  } srn_cfg_s;

  typedef struct packed {
    logic valid;
    logic [PRIO_W-1:0] prio;
  } srn_bus_s;

endpackage : srn_pkg

`default_nettype wire

// [srn_node.sv]
// one service request node: pending flag, enable, select, priority
`default_nettype none

module srn_node
  import srn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic trigger,
  input wire logic ack,
  input wire logic sw_wr,
  input wire logic [3:0] sw_be,
  input wire logic [31:0] sw_wdata,
  input wire logic hw_hold,
  output srn_cfg_s cfg,
  output logic pending,
  output srn_bus_s cpu_bus,
  output srn_bus_s cop_bus
);

  srn_cfg_s cfg_q;
  srn_cfg_s cfg_d;
  logic pend_q;
  logic pend_d;
  wire logic lane0 = sw_wr & sw_be[0];
  wire logic lane1 = sw_wr & sw_be[1];
  wire logic do_set = lane1 & sw_wdata[SET_BIT];
  wire logic do_clr = lane1 & sw_wdata[CLR_BIT];
  wire logic sw_owns = sw_wr | hw_hold;
  wire logic eligible = pend_q & cfg_q.en & (cfg_q.prio != PRIO_RST);

  always_comb begin
    cfg_d = cfg_q;
    if (lane0) begin
      cfg_d.prio = sw_wdata[PRIO_LSB +: PRIO_W];
    end
    if (lane1) begin
      cfg_d.sel = sw_wdata[SEL_LO_BIT];
      cfg_d.en = sw_wdata[EN_BIT];
    end
  end

  always_comb begin
    // pending bit of write data never read
    pend_d = pend_q;
    // set or clear alone acts, both hold
    if (do_set & ~do_clr) begin
      pend_d = 1'b1;
    end else if (do_clr & ~do_set) begin
      pend_d = 1'b0;
    end else if (sw_owns) begin
      pend_d = pend_q;
    end else if (trigger) begin
      pend_d = 1'b1;
    end else if (ack) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '{prio: PRIO_RST, sel: SEL_RST, en: EN_RST};
      pend_q <= PEND_RST;
    end else begin
      cfg_q <= cfg_d;
      pend_q <= pend_d;
    end
  end

  assign cfg = cfg_q;
  assign pending = pend_q;
  assign cpu_bus = '{valid: eligible & (cfg_q.sel == SEL_CPU), prio: cfg_q.prio};
  assign cop_bus = '{valid: eligible & (cfg_q.sel == SEL_COP), prio: cfg_q.prio};

endmodule : srn_node

`default_nettype wire

// [srn_arb.sv]
// arbitration unit of one provider: highest priority number wins
`default_nettype none

module srn_arb
  import srn_pkg::*;
#(
  parameter int NUM_NODES = 4,
  parameter int IDX_W = 2
)
(
  input wire logic clk,
  input wire logic reset,
  input wire srn_bus_s bus [NUM_NODES],
  input wire logic prov_ack,
  output logic win_valid,
  output logic [PRIO_W-1:0] win_prio,
  output logic [IDX_W-1:0] win_idx,
  output logic [NUM_NODES-1:0] node_ack
);

  logic best_valid;
  logic [PRIO_W-1:0] best_prio;
  logic [IDX_W-1:0] best_idx;
  logic win_valid_q;
  logic [PRIO_W-1:0] win_prio_q;
  logic [IDX_W-1:0] win_idx_q;

  always_comb begin
    best_valid = 1'b0;
    best_prio = PRIO_RST;
    best_idx = '0;
    for (int i = 0; i < NUM_NODES; i++) begin
      if (bus[i].valid && (bus[i].prio > best_prio)) begin
        best_valid = 1'b1;
        best_prio = bus[i].prio;
        best_idx = IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      win_valid_q <= 1'b0;
      win_prio_q <= PRIO_RST;
      win_idx_q <= '0;
    end else begin
      win_valid_q <= best_valid;
      win_prio_q <= best_prio;
      win_idx_q <= best_idx;
    end
  end

  // acknowledge routed to the presented winner
  always_comb begin
    node_ack = '0;
    if (prov_ack && win_valid_q) begin
      node_ack[win_idx_q] = 1'b1;
    end
  end

  assign win_valid = win_valid_q;
  assign win_prio = win_prio_q;
  assign win_idx = win_idx_q;

endmodule : srn_arb

`default_nettype wire

// [srn_top.sv]
// service request nodes with avalon-mm slave and two arbitration units
`default_nettype none

module srn_top
  import srn_pkg::*;
#(
  parameter int NUM_NODES = 4,
  parameter int IDX_W = 2
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_lock,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_NODES-1:0] trigger,
  input wire logic cpu_ack,
  input wire logic cop_ack,
  output logic cpu_req_valid,
  output logic [PRIO_W-1:0] cpu_req_prio,
  output logic cop_req_valid,
  output logic [PRIO_W-1:0] cop_req_prio
);

  // ---------------------------------------------------------------
  // address decoding
  // ---------------------------------------------------------------
  function automatic logic node_hit(input logic [ADDR_W-1:0] a, input int n);
    node_hit = (a[ADDR_W-1:2] == (NODE_BASE[ADDR_W-1:2] + (ADDR_W-2)'(n)));
  endfunction : node_hit

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    reg_hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
  endfunction : reg_hit

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire logic req = avs_read | avs_write;
  // answer cycle: waitrequest low, write lands here
  wire logic accept = req & ~wait_q;
  wire logic wr_accept = accept & avs_write;
  wire logic rd_accept = accept & avs_read;

  always_comb begin
    wait_d = 1'b1;
    if (req && wait_q) begin
      wait_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // ---------------------------------------------------------------
  // nodes
  // ---------------------------------------------------------------
  srn_cfg_s cfg [NUM_NODES];
  logic [NUM_NODES-1:0] pending;
  srn_bus_s cpu_bus [NUM_NODES];
  srn_bus_s cop_bus [NUM_NODES];
  logic [NUM_NODES-1:0] cpu_node_ack;
  logic [NUM_NODES-1:0] cop_node_ack;
  logic [NUM_NODES-1:0] node_wr;
  logic [NUM_NODES-1:0] node_rd;
  logic [NUM_NODES-1:0] hold_q;
  logic [NUM_NODES-1:0] hold_d;
  logic [NUM_NODES-1:0] node_hold;

  genvar g;
  generate
    for (g = 0; g < NUM_NODES; g++) begin : g_node
      assign node_wr[g] = wr_accept & node_hit(avs_address, g);
      assign node_rd[g] = rd_accept & node_hit(avs_address, g);
      // locked read opens an atomic window
      assign hold_d[g] = avs_lock & (hold_q[g] | node_rd[g]) & ~node_wr[g];
      assign node_hold[g] = hold_q[g] & avs_lock;

      srn_node u_node (
        .clk(clk),
        .reset(reset),
        .trigger(trigger[g]),
        .ack(cpu_node_ack[g] | cop_node_ack[g]),
        .sw_wr(node_wr[g]),
        .sw_be(avs_byteenable),
        .sw_wdata(avs_writedata),
        .hw_hold(node_hold[g]),
        .cfg(cfg[g]),
        .pending(pending[g]),
        .cpu_bus(cpu_bus[g]),
        .cop_bus(cop_bus[g])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ---------------------------------------------------------------
  // arbitration units
  // ---------------------------------------------------------------
  logic cpu_win_valid;
  logic [PRIO_W-1:0] cpu_win_prio;
  logic [IDX_W-1:0] cpu_win_idx;
  logic cop_win_valid;
  logic [PRIO_W-1:0] cop_win_prio;
  logic [IDX_W-1:0] cop_win_idx;

  // one unit per provider, own bus each
  srn_arb #(
    .NUM_NODES(NUM_NODES),
    .IDX_W(IDX_W)
  ) u_cpu_arb (
    .clk(clk),
    .reset(reset),
    .bus(cpu_bus),
    .prov_ack(cpu_ack),
    .win_valid(cpu_win_valid),
    .win_prio(cpu_win_prio),
    .win_idx(cpu_win_idx),
    .node_ack(cpu_node_ack)
  );

  srn_arb #(
    .NUM_NODES(NUM_NODES),
    .IDX_W(IDX_W)
  ) u_cop_arb (
    .clk(clk),
    .reset(reset),
    .bus(cop_bus),
    .prov_ack(cop_ack),
    .win_valid(cop_win_valid),
    .win_prio(cop_win_prio),
    .win_idx(cop_win_idx),
    .node_ack(cop_node_ack)
  );

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] node_word [NUM_NODES];

  generate
    for (g = 0; g < NUM_NODES; g++) begin : g_word
      // set, clear and upper select read zero
      assign node_word[g] = {16'h0000,
                             1'b0,
                             1'b0,
                             pending[g],
                             cfg[g].en,
                             1'b0,
                             cfg[g].sel,
                             2'b00,
                             cfg[g].prio};
    end
  endgenerate

  wire logic [31:0] pend_word = 32'(pending);
  wire logic [31:0] cpu_word = {15'h0000, cpu_win_valid, 8'(cpu_win_idx), cpu_win_prio};
  wire logic [31:0] cop_word = {15'h0000, cop_win_valid, 8'(cop_win_idx), cop_win_prio};

  always_comb begin
    rdata_d = RDATA_RST;
    for (int i = 0; i < NUM_NODES; i++) begin
      if (node_hit(avs_address, i)) begin
        rdata_d = node_word[i];
      end
    end
    if (reg_hit(avs_address, PEND_STATUS_OFS)) begin
      rdata_d = pend_word;
    end
    if (reg_hit(avs_address, CPU_WIN_OFS)) begin
      rdata_d = cpu_word;
    end
    if (reg_hit(avs_address, COP_WIN_OFS)) begin
      rdata_d = cop_word;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= RDATA_RST;
    end else if (avs_read && wait_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  // winner priority presented as vector index
  assign cpu_req_valid = cpu_win_valid;
  assign cpu_req_prio = cpu_win_prio;
  assign cop_req_valid = cop_win_valid;
  assign cop_req_prio = cop_win_prio;

endmodule : srn_top

`default_nettype wire

// [srn_top_asserts.sv]
// port checker of the service request node top
`default_nettype none

module srn_top_asserts
  import srn_pkg::*;
#(
  parameter int NUM_NODES = 4,
  parameter int IDX_W = 2
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cpu_req_valid,
  input wire logic [PRIO_W-1:0] cpu_req_prio,
  input wire logic cop_req_valid,
  input wire logic [PRIO_W-1:0] cop_req_prio
);
  // ---
  // node word answers
  // ---
  wire logic node_ans;
  assign node_ans = avs_read && !avs_waitrequest && (int'(avs_address[ADDR_W-1:2]) < NUM_NODES);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
  property p_strobe_rd0;
    node_ans |-> avs_readdata[SET_BIT:CLR_BIT] == 2'b00;
  endproperty
  a_strobe_rd0: assert property (p_strobe_rd0) else $error("set or clear bit read high");
  property p_sel_hi;
    node_ans |-> !avs_readdata[SEL_HI_BIT];
  endproperty
  a_sel_hi: assert property (p_sel_hi) else $error("upper select bit read high");
  property p_prio_w;
    node_ans |-> avs_readdata[31:16] == 16'h0000 && avs_readdata[9:8] == 2'b00;
  endproperty
  a_prio_w: assert property (p_prio_w) else $error("node word reserved bits set");
  property p_cpu_nz;
    cpu_req_valid |-> cpu_req_prio != 8'h00;
  endproperty
  a_cpu_nz: assert property (p_cpu_nz) else $error("cpu request with priority zero");
  property p_cop_nz;
    cop_req_valid |-> cop_req_prio != 8'h00;
  endproperty
  a_cop_nz: assert property (p_cop_nz) else $error("cop request with priority zero");
  property p_idle;
    !cpu_req_valid && !cop_req_valid |-> (cpu_req_prio | cop_req_prio) == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("priority shown without request");
endmodule : srn_top_asserts

bind srn_top srn_top_asserts #(.NUM_NODES(NUM_NODES), .IDX_W(IDX_W)) srn_top_asserts_i (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cpu_req_valid(cpu_req_valid), .cpu_req_prio(cpu_req_prio),
  .cop_req_valid(cop_req_valid), .cop_req_prio(cop_req_prio)
);

`default_nettype wire

// [srn_prov_model.sv]
// provider partner: acknowledges the presented winner
`default_nettype none

module srn_prov_model
  import srn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [3:0] dly,
  input wire logic req_valid,
  input wire logic [PRIO_W-1:0] req_prio,
  output logic ack,
  output logic [PRIO_W-1:0] vec_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic [1:0] gap_q;
  // gap covers flag and winner register lag
  always_ff @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
      cnt_q <= 4'h0;
      gap_q <= 2'h0;
      vec_q <= 8'h00;
    end else if (ack) begin
      ack <= 1'b0;
      gap_q <= 2'h3;
    end else if (gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
    end else if (go && req_valid) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= dly) begin
        ack <= 1'b1;
        vec_q <= req_prio;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule : srn_prov_model

`default_nettype wire

// [srn_top_tb.sv]
// self-checking bench of the service request node top
`default_nettype none

module srn_top_tb
  import srn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, avs_read, avs_write, avs_lock, avs_waitrequest, go;
  logic cpu_ack, cop_ack, cpu_req_valid, cop_req_valid;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, trigger, dly, xpend;
  logic [PRIO_W-1:0] cpu_req_prio, cop_req_prio, cpu_vec, cop_vec;
  logic [7:0] xp [4];
  logic xs [4];
  int n_fail, n_checks, cyc;

  srn_top #(.NUM_NODES(4), .IDX_W(2)) srn_top_i (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_lock(avs_lock),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger(trigger),
    .cpu_ack(cpu_ack), .cop_ack(cop_ack), .cpu_req_valid(cpu_req_valid),
    .cpu_req_prio(cpu_req_prio), .cop_req_valid(cop_req_valid), .cop_req_prio(cop_req_prio));
  srn_prov_model srn_prov_model_cpu_i (.clk(clk), .reset(reset), .go(go), .dly(dly),
    .req_valid(cpu_req_valid), .req_prio(cpu_req_prio), .ack(cpu_ack), .vec_q(cpu_vec));
  srn_prov_model srn_prov_model_cop_i (.clk(clk), .reset(reset), .go(go), .dly(dly),
    .req_valid(cop_req_valid), .req_prio(cop_req_prio), .ack(cop_ack), .vec_q(cop_vec));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk32

  task automatic chk1(input string nm, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1

  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic lk);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    avs_lock <= lk;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 1'b0);
    chk32("readdata", e, q);
  endtask : rdc

  task automatic pulse(input logic [3:0] t);
    @(posedge clk);
    trigger <= t;
    @(posedge clk);
    trigger <= 4'h0;
  endtask : pulse

  function automatic logic [31:0] nw(logic [7:0] p, logic s, logic en, logic c, logic st);
    return {16'h0000, st, c, 1'b0, en, 1'b0, s, 2'b00, p};
  endfunction : nw

  function automatic logic [8:0] best(logic p);
    logic [8:0] b;
    b = 9'h000;
    for (int i = 0; i < 4; i++) if (xpend[i] && xs[i] == p && xp[i] > b[7:0]) b = {1'b1, xp[i]};
    return b;
  endfunction : best

  task automatic ack_chk(input logic p, input logic [7:0] seen, input logic [7:0] vec);
    logic [8:0] b;
    b = best(p);
    chk32("winner", {23'h0, b}, {23'h0, 1'b1, seen});
    chk32("vector", {24'h0, b[7:0]}, {24'h0, vec});
    for (int i = 0; i < 4; i++) if (xpend[i] && xs[i] == p && xp[i] == b[7:0]) xpend[i] = 1'b0;
  endtask : ack_chk

  always @(posedge clk) begin
    cyc++;
    if (cpu_ack === 1'b1) ack_chk(1'b0, cpu_req_prio, cpu_vec);
    if (cop_ack === 1'b1) ack_chk(1'b1, cop_req_prio, cop_vec);
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    {reset, avs_read, avs_write, avs_lock, go} = 5'h1f & 5'h10;
    {avs_address, avs_writedata, q} = '0;
    {avs_byteenable, trigger, dly, xpend} = 16'hf000;
    {n_fail, n_checks, cyc} = '0;
    void'($urandom(91));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(9'(4 * i), 32'h0000_0000);
    rdc(9'h1fc, 32'h0000_0000);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b0, 1'b0), 1'b0);
    pulse(4'h1);
    rdc(9'h000, 32'h0000_2005);
    chk1("cpu_req_valid", 1'b0, cpu_req_valid);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b1, 1'b1), 1'b0);
    rdc(9'h000, 32'h0000_2005);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b1, 1'b0), 1'b0);
    rdc(9'h000, 32'h0000_0005);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b0, 1'b0) | 32'h0000_2000, 1'b0);
    rdc(9'h000, 32'h0000_0005);
    avs_byteenable <= 4'h1;
    bus(1'b1, 9'h000, nw(8'h07, 1'b0, 1'b1, 1'b0, 1'b1), 1'b0);
    avs_byteenable <= 4'hf;
    rdc(9'h000, 32'h0000_0007);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b0, 1'b1) | 32'h0000_0800, 1'b0);
    rdc(9'h000, 32'h0000_2005);
    bus(1'b1, 9'h000, nw(8'h00, 1'b0, 1'b1, 1'b0, 1'b0), 1'b0);
    rdc(9'h104, 32'h0000_0000);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b1, 1'b0, 1'b0), 1'b0);
    rdc(9'h104, 32'h0001_0005);
    chk1("cop_req_valid", 1'b0, cop_req_valid);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b1, 1'b0), 1'b0);
    bus(1'b0, 9'h000, 32'h0000_0000, 1'b1);
    pulse(4'h1);
    bus(1'b1, 9'h000, nw(8'h05, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
    rdc(9'h000, 32'h0000_0005);
    for (int r = 0; r < 4; r++) begin
      int base;
      base = (r == 0) ? 254 : $urandom_range(0, 254);
      dly <= 4'($urandom_range(0, 7));
      for (int i = 0; i < 4; i++) begin
        xp[i] = 8'((base + 61 * i) % 255 + 1);
        xs[i] = (r == 1) ? 1'b0 : (r == 2) ? 1'b1 : 1'($urandom_range(0, 1));
        bus(1'b1, 9'(4 * i), nw(xp[i], xs[i], 1'b1, 1'b0, 1'b0), 1'b0);
      end
      xpend = 4'hf;
      go <= 1'b1;
      pulse(4'hf);
      while (xpend !== 4'h0) @(posedge clk);
      repeat (4) @(posedge clk);
      rdc(9'h100, 32'h0000_0000);
    end
    close_out();
  end
endmodule : srn_top_tb

`default_nettype wire
